// file: src/coarse_delay.sv
// output-word delay line for one voltage/current pair
`timescale 1ns/1ns
`default_nettype none
module coarse_delay (
	input  wire logic        ref_clk,  // system clock
	input  wire logic        rstn,     // async reset, active low
	input  wire logic        owr_tick, // one pulse per output word
	input  wire logic [1:0]  mode,     // coarse delay select
	input  wire logic [23:0] i_in,     // current sample
	input  wire logic [23:0] v_in,     // voltage sample
	output logic      [23:0] i_out,    // aligned current
	output logic      [23:0] v_out     // aligned voltage
);
	typedef struct packed {
		logic [23:0] i_d1;
		logic [23:0] v_d1;
		logic [23:0] v_d2;
		logic [23:0] i_o;
		logic [23:0] v_o;
	} cd_st_t;
	cd_st_t st_r, st_nxt;

	// taps are picked before the shift, so d1 is exactly one word old
	always_comb begin
		st_nxt = st_r;
		if (owr_tick) begin
			st_nxt.i_d1 = i_in;
			st_nxt.v_d1 = v_in;
			st_nxt.v_d2 = st_r.v_d1;
			st_nxt.i_o  = (mode == meter_cfg_pkg::CD_I1) ? st_r.i_d1 : i_in;
			case (mode)
				meter_cfg_pkg::CD_V1: st_nxt.v_o = st_r.v_d1;
				meter_cfg_pkg::CD_V2: st_nxt.v_o = st_r.v_d2;
				default: st_nxt.v_o = v_in;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign i_out = st_r.i_o;
	assign v_out = st_r.v_o;
endmodule
`default_nettype wire

// file: src/meter_cfg_pkg.sv
// shared constants for the meter configuration register bank
package meter_cfg_pkg;
	// ---------------------------------------------------------------
	// register locations (page, address)
	// ---------------------------------------------------------------
	localparam logic [5:0] PAGE_MAIN     = 6'h00;
	localparam logic [5:0] PAGE_CAL      = 6'h10;
	localparam logic [5:0] ADDR_PIN_CFG  = 6'h01; // page 0
	localparam logic [5:0] ADDR_PATH_CFG = 6'h00; // page 16
	localparam logic [5:0] ADDR_PHASE    = 6'h05; // page 0
	localparam logic [5:0] ADDR_SERIAL   = 6'h07; // page 0
	localparam logic [5:0] ADDR_PULSE    = 6'h08; // page 0
	// ---------------------------------------------------------------
	// reset values and writable masks
	// ---------------------------------------------------------------
	localparam logic [23:0] RST_PIN_CFG  = 24'h00eeee;
	localparam logic [23:0] RST_PATH_CFG = 24'h060200;
	localparam logic [23:0] RST_PHASE    = 24'h000000;
	localparam logic [23:0] RST_SERIAL   = 24'h02004d;
	localparam logic [23:0] RST_PULSE    = 24'h000001;
	localparam logic [23:0] WM_PIN_CFG   = 24'hffffff;
	localparam logic [23:0] WM_PATH_CFG  = 24'h405fff;
	localparam logic [23:0] FIX_PATH_CFG = 24'h060000; // bits fixed at one
	localparam logic [23:0] WM_PHASE     = 24'hf3ffff;
	localparam logic [23:0] WM_SERIAL    = 24'h06ffff;
	localparam logic [23:0] WM_PULSE     = 24'h0fffff;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int PG_EN_LSB   = 20;
	localparam int OD_LSB      = 16;
	localparam int POS_BIT     = 22;
	localparam int APPARENT_POWER_METHOD_BIT    = 14;
	localparam int ZXLPF_BIT   = 12;
	localparam int AVG_BIT     = 11;
	localparam int CSUM_BIT    = 10;
	localparam int AFC_BIT     = 9;
	localparam int I2F_LSB     = 7;
	localparam int V2F_LSB     = 5;
	localparam int I1F_LSB     = 3;
	localparam int V1F_LSB     = 1;
	localparam int IIR_BIT     = 0;
	localparam int CP2_LSB     = 22;
	localparam int CP1_LSB     = 20;
	localparam int FP2_LSB     = 9;
	localparam int FP1_LSB     = 0;
	localparam int RXPU_BIT    = 18;
	localparam int RXCS_BIT    = 17;
	localparam int RNG_LSB     = 16;
	// ---------------------------------------------------------------
	// pin source codes and coarse delay modes
	// ---------------------------------------------------------------
	localparam logic [3:0] SRC_SIGN_LO = 4'h4;
	localparam logic [3:0] SRC_SIGN_HI = 4'h9;
	localparam logic [3:0] SRC_VZX     = 4'hb;
	localparam logic [3:0] SRC_IZX     = 4'hc;
	localparam logic [3:0] SRC_HIZ     = 4'he;
	localparam logic [3:0] SRC_IRQ     = 4'hf;
	localparam logic [1:0] CD_NONE     = 2'h0;
	localparam logic [1:0] CD_I1       = 2'h1;
	localparam logic [1:0] CD_V1       = 2'h2;
	localparam logic [1:0] CD_V2       = 2'h3;
	// ---------------------------------------------------------------
	// pulse timing: base time plus width steps of 1/64000 s
	// ---------------------------------------------------------------
	localparam int CLK_HZ         = 100_000_000;
	localparam int PULSE_BASE_US  = 250;
	localparam int PULSE_STEP_HZ  = 64_000;
	localparam int PULSE_BASE_CYC = PULSE_BASE_US * (CLK_HZ / 1_000_000);
	localparam int PULSE_STEP_HLF = (2 * CLK_HZ) / PULSE_STEP_HZ; // half cycles
endpackage

// file: src/meter_config_registers.sv
// configuration register bank and digital output routing of the meter front end
// What this block does
// - four pulse generator enables, all disabled after reset.
// - one open-drain select bit per digital output, normal drive default.
// - source codes 0 to 3 route pulse generators one to four.
// - codes 4 to 9 route the six power sign signals in order.
// - code 11 routes voltage zero-cross, code 12 current zero-cross.
// - code 14 (reset) leaves pin undriven, 15 routes interrupt; 10, 13 reserved.
// - positive-only bit stores zero for negative averaged active power.
// - apparent power method: rms product when zero, root of squares when one.
// - zero-cross low-pass enable, off after reset.
// - averaging basis: sample count when zero, line cycles when one.
// - critical register checksum runs unless its disable bit is set.
// - auto line frequency updates integrator gain on each new measurement.
// - current filter select: none, high-pass, phase-match, coil integrator.
// - voltage filter select: none, high-pass, phase-match; code 3 reserved.
// - one bit bypasses the IIR stage; stage in path after reset.
// - per pair coarse delay: none, current one word, voltage one or two.
// - per pair nine-bit fine delay of current relative to voltage.
// - receive pull-up disable bit, pull-up present after reset.
// - serial checksum disable, set after reset; cleared means data checked.
// - sixteen-bit bit rate divisor for the serial port.
// - pulse length is 250 us plus width value over 64000 seconds.
// - four-bit pulse frequency range field, code 0 after reset.
`timescale 1ns/1ns
`default_nettype none
module meter_config_registers #(
	parameter int PULSE_BASE_CYCLES = meter_cfg_pkg::PULSE_BASE_CYC, // pulse base time
	parameter int PULSE_STEP_HALVES = meter_cfg_pkg::PULSE_STEP_HLF  // width step, half cycles
) (
	input  wire logic        ref_clk,          // 100 MHz system clock
	input  wire logic        rstn,             // async reset, active low
	// register access from the serial port engine
	input  wire logic        reg_wr,           // write strobe
	input  wire logic        reg_rd,           // read strobe
	input  wire logic [5:0]  reg_page,         // page of access
	input  wire logic [5:0]  reg_addr,         // address in page
	input  wire logic [23:0] reg_wdata,        // write data
	output logic      [23:0] reg_rdata,        // read data, valid after reg_rd
	output logic             reg_hit,          // last read hit a register here
	// signal sources for the digital outputs
	input  wire logic [3:0]  gen_fire,         // raw pulse events per generator
	input  wire logic [5:0]  power_sign,       // p1,p2,psum,q1,q2,qsum signs
	input  wire logic        volt_zero_cross,  // selected voltage zero-cross
	input  wire logic        curr_zero_cross,  // selected current zero-cross
	input  wire logic        irq_level,        // interrupt signal
	output logic      [3:0]  dout_o,           // digital output values
	output logic      [3:0]  dout_oe,          // output enables, high drives
	// averaged active power results
	input  wire logic        p_avg_valid,      // new results present
	input  wire logic [23:0] p1_avg_in,        // channel 1 averaged power
	input  wire logic [23:0] p2_avg_in,        // channel 2 averaged power
	output logic      [23:0] p1_avg_store,     // stored channel 1 value
	output logic      [23:0] p2_avg_store,     // stored channel 2 value
	// line frequency
	input  wire logic        freq_meas_done,   // new line frequency ready
	output logic             epsilon_update,   // load integrator gain pulse
	// phase compensation datapath
	input  wire logic        owr_tick,         // output word rate enable
	input  wire logic [23:0] i1_in,            // current 1 sample
	input  wire logic [23:0] v1_in,            // voltage 1 sample
	input  wire logic [23:0] i2_in,            // current 2 sample
	input  wire logic [23:0] v2_in,            // voltage 2 sample
	output logic      [23:0] i1_out,           // aligned current 1
	output logic      [23:0] v1_out,           // aligned voltage 1
	output logic      [23:0] i2_out,           // aligned current 2
	output logic      [23:0] v2_out,           // aligned voltage 2
	output logic      [8:0]  fine_phase_pair1, // fine delay pair 1
	output logic      [8:0]  fine_phase_pair2, // fine delay pair 2
	// configuration levels to the signal chain
	output logic             apparent_power_method,     // 1 = root of squares
	output logic             zero_cross_lowpass,        // zero-cross filter on
	output logic             averaging_basis,           // 1 = line cycles
	output logic             critical_checksum_disable, // stop register checksum
	output logic [1:0]       current1_filter_select,    // current 1 filter
	output logic [1:0]       current2_filter_select,    // current 2 filter
	output logic [1:0]       voltage1_filter_select,    // voltage 1 filter
	output logic [1:0]       voltage2_filter_select,    // voltage 2 filter
	output logic             decimation_lowpass_bypass, // IIR bypass
	output logic             receive_pullup_disable,    // rx pull-up off
	output logic             serial_checksum_disable,   // serial checksum off
	output logic [15:0]      bit_rate_divisor,          // serial bit rate
	output logic [3:0]       pulse_freq_range           // pulse range select
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [23:0] pin_cfg;
		logic [23:0] path_cfg;
		logic [23:0] phase;
		logic [23:0] serial;
		logic [23:0] pulse;
		logic [23:0] rdata;
		logic        hit;
		logic [3:0]  pin_o;
		logic [3:0]  pin_oe;
		logic [23:0] p1_st;
		logic [23:0] p2_st;
		logic        eps;
	} bank_st_t;
	bank_st_t st_r, st_nxt;

	logic [3:0] pulses;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// merge a write into a register, keeping read-only bits
	function automatic logic [23:0] merge(input logic [23:0] old, input logic [23:0] wd,
	                                      input logic [23:0] wm);
		return (old & ~wm) | (wd & wm);
	endfunction

	// pick what one output pin carries: {drive, value}
	function automatic logic [1:0] route(input logic [3:0] code, input logic [3:0] pg,
	                                     input logic [5:0] sgn, input logic vzx,
	                                     input logic izx, input logic irq);
		logic [1:0] r;
		r = 2'b00;
		if (code < meter_cfg_pkg::SRC_SIGN_LO)
			r = {1'b1, pg[code[1:0]]};
		else if (code <= meter_cfg_pkg::SRC_SIGN_HI)
			r = {1'b1, sgn[3'(code - meter_cfg_pkg::SRC_SIGN_LO)]};
		else if (code == meter_cfg_pkg::SRC_VZX)
			r = {1'b1, vzx};
		else if (code == meter_cfg_pkg::SRC_IZX)
			r = {1'b1, izx};
		else if (code == meter_cfg_pkg::SRC_IRQ)
			r = {1'b1, irq};
		else
			r = 2'b00; // hi-z, and reserved codes stay off the pin
		return r;
	endfunction

	// negative results are replaced by zero when positive-only is set
	function automatic logic [23:0] clamp(input logic [23:0] v, input logic pos);
		return (pos && v[23]) ? 24'h000000 : v;
	endfunction

	// ---------------------------------------------------------------
	// register write and read
	// ---------------------------------------------------------------
	logic sel_pin, sel_path, sel_phase, sel_serial, sel_pulse;

	always_comb begin
		sel_pin    = (reg_page == meter_cfg_pkg::PAGE_MAIN) && (reg_addr == meter_cfg_pkg::ADDR_PIN_CFG);
		sel_path   = (reg_page == meter_cfg_pkg::PAGE_CAL) && (reg_addr == meter_cfg_pkg::ADDR_PATH_CFG);
		sel_phase  = (reg_page == meter_cfg_pkg::PAGE_MAIN) && (reg_addr == meter_cfg_pkg::ADDR_PHASE);
		sel_serial = (reg_page == meter_cfg_pkg::PAGE_MAIN) && (reg_addr == meter_cfg_pkg::ADDR_SERIAL);
		sel_pulse  = (reg_page == meter_cfg_pkg::PAGE_MAIN) && (reg_addr == meter_cfg_pkg::ADDR_PULSE);
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [1:0] rt;
		logic       od;
		rt = 2'b00;
		od = 1'b0;
		st_nxt = st_r;
		// writes: reserved bits hold their reset value
		if (reg_wr) begin
			if (sel_pin)
				st_nxt.pin_cfg = merge(st_r.pin_cfg, reg_wdata, meter_cfg_pkg::WM_PIN_CFG);
			if (sel_path)
				st_nxt.path_cfg = merge(st_r.path_cfg, reg_wdata, meter_cfg_pkg::WM_PATH_CFG)
				                  | meter_cfg_pkg::FIX_PATH_CFG;
			if (sel_phase)
				st_nxt.phase = merge(st_r.phase, reg_wdata, meter_cfg_pkg::WM_PHASE);
			if (sel_serial)
				st_nxt.serial = merge(st_r.serial, reg_wdata, meter_cfg_pkg::WM_SERIAL);
			if (sel_pulse)
				st_nxt.pulse = merge(st_r.pulse, reg_wdata, meter_cfg_pkg::WM_PULSE);
		end
		// reads answer one cycle later; unmapped locations read zero
		if (reg_rd) begin
			st_nxt.hit = sel_pin | sel_path | sel_phase | sel_serial | sel_pulse;
			st_nxt.rdata = ({24{sel_pin}} & st_r.pin_cfg)
			             | ({24{sel_path}} & st_r.path_cfg)
			             | ({24{sel_phase}} & st_r.phase)
			             | ({24{sel_serial}} & st_r.serial)
			             | ({24{sel_pulse}} & st_r.pulse);
		end
		// output pins: open-drain only ever pulls low
		for (int p = 0; p < 4; p++) begin
			rt = route(st_r.pin_cfg[4*p +: 4], pulses, power_sign,
			           volt_zero_cross, curr_zero_cross, irq_level);
			od = st_r.pin_cfg[meter_cfg_pkg::OD_LSB + p];
			if (od) begin
				st_nxt.pin_o[p]  = 1'b0;
				st_nxt.pin_oe[p] = rt[1] & ~rt[0];
			end else begin
				st_nxt.pin_o[p]  = rt[0];
				st_nxt.pin_oe[p] = rt[1];
			end
		end
		// averaged power store with positive-only clamp
		if (p_avg_valid) begin
			st_nxt.p1_st = clamp(p1_avg_in, st_r.path_cfg[meter_cfg_pkg::POS_BIT]);
			st_nxt.p2_st = clamp(p2_avg_in, st_r.path_cfg[meter_cfg_pkg::POS_BIT]);
		end
		// gain reload only follows a finished measurement
		st_nxt.eps = freq_meas_done & st_r.path_cfg[meter_cfg_pkg::AFC_BIT];
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_r          <= '0;
			st_r.pin_cfg  <= meter_cfg_pkg::RST_PIN_CFG;
			st_r.path_cfg <= meter_cfg_pkg::RST_PATH_CFG;
			st_r.phase    <= meter_cfg_pkg::RST_PHASE;
			st_r.serial   <= meter_cfg_pkg::RST_SERIAL;
			st_r.pulse    <= meter_cfg_pkg::RST_PULSE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ---------------------------------------------------------------
	// pulse generators and phase alignment
	// ---------------------------------------------------------------
	// a disabled generator produces no pulses at all
	pulse_stretch #(
		.BASE_CYC (PULSE_BASE_CYCLES),
		.STEP_HLF (PULSE_STEP_HALVES)
	) u_pulse (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.fire    (gen_fire),
		.enable  (st_r.pin_cfg[meter_cfg_pkg::PG_EN_LSB +: 4]),
		.width   (st_r.pulse[15:0]),
		.pulse   (pulses)
	);

	coarse_delay u_pair1 (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.owr_tick (owr_tick),
		.mode     (st_r.phase[meter_cfg_pkg::CP1_LSB +: 2]),
		.i_in     (i1_in),
		.v_in     (v1_in),
		.i_out    (i1_out),
		.v_out    (v1_out)
	);

	coarse_delay u_pair2 (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.owr_tick (owr_tick),
		.mode     (st_r.phase[meter_cfg_pkg::CP2_LSB +: 2]),
		.i_in     (i2_in),
		.v_in     (v2_in),
		.i_out    (i2_out),
		.v_out    (v2_out)
	);

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign reg_rdata      = st_r.rdata;
	assign reg_hit        = st_r.hit;
	assign dout_o         = st_r.pin_o;
	assign dout_oe        = st_r.pin_oe;
	assign p1_avg_store   = st_r.p1_st;
	assign p2_avg_store   = st_r.p2_st;
	assign epsilon_update = st_r.eps;

	// fine delay steps are consumed by the interpolator downstream
	assign fine_phase_pair1 = st_r.phase[meter_cfg_pkg::FP1_LSB +: 9];
	assign fine_phase_pair2 = st_r.phase[meter_cfg_pkg::FP2_LSB +: 9];

	// configuration levels straight from the registers
	assign apparent_power_method     = st_r.path_cfg[meter_cfg_pkg::APPARENT_POWER_METHOD_BIT];
	assign zero_cross_lowpass        = st_r.path_cfg[meter_cfg_pkg::ZXLPF_BIT];
	assign averaging_basis           = st_r.path_cfg[meter_cfg_pkg::AVG_BIT];
	assign critical_checksum_disable = st_r.path_cfg[meter_cfg_pkg::CSUM_BIT];
	assign current1_filter_select    = st_r.path_cfg[meter_cfg_pkg::I1F_LSB +: 2];
	assign current2_filter_select    = st_r.path_cfg[meter_cfg_pkg::I2F_LSB +: 2];
	// code 3 is reserved; it is passed on as written
	assign voltage1_filter_select    = st_r.path_cfg[meter_cfg_pkg::V1F_LSB +: 2];
	assign voltage2_filter_select    = st_r.path_cfg[meter_cfg_pkg::V2F_LSB +: 2];
	assign decimation_lowpass_bypass = st_r.path_cfg[meter_cfg_pkg::IIR_BIT];
	assign receive_pullup_disable    = st_r.serial[meter_cfg_pkg::RXPU_BIT];
	assign serial_checksum_disable   = st_r.serial[meter_cfg_pkg::RXCS_BIT];
	assign bit_rate_divisor          = st_r.serial[15:0];
	assign pulse_freq_range          = st_r.pulse[meter_cfg_pkg::RNG_LSB +: 4];
endmodule
`default_nettype wire

// file: src/pulse_stretch.sv
// four energy pulse stretchers with programmable duration
`timescale 1ns/1ns
`default_nettype none
module pulse_stretch #(
	parameter int BASE_CYC = meter_cfg_pkg::PULSE_BASE_CYC, // base time in cycles
	parameter int STEP_HLF = meter_cfg_pkg::PULSE_STEP_HLF  // width step, half cycles
) (
	input  wire logic        ref_clk, // system clock
	input  wire logic        rstn,    // async reset, active low
	input  wire logic [3:0]  fire,    // one-cycle pulse requests
	input  wire logic [3:0]  enable,  // generator enables
	input  wire logic [15:0] width,   // width register value
	output logic      [3:0]  pulse    // stretched pulses
);
	typedef struct packed {
		logic [3:0][27:0] cnt;
		logic [3:0]       act;
	} ps_st_t;
	ps_st_t st_r, st_nxt;
	logic [27:0] dur;

	// length = base + width * step / 2, the half cycle truncated
	function automatic logic [27:0] duration(input logic [15:0] w);
		logic [43:0] p;
		p = 44'(w) * 44'(STEP_HLF);
		return 28'(BASE_CYC) + p[28:1];
	endfunction

	assign dur = duration(width);

	// a fire while a pulse runs is ignored; disabling kills the pulse
	always_comb begin
		st_nxt = st_r;
		for (int g = 0; g < 4; g++) begin
			if (!enable[g]) begin
				st_nxt.act[g] = 1'b0;
				st_nxt.cnt[g] = '0;
			end else if (st_r.act[g]) begin
				st_nxt.cnt[g] = st_r.cnt[g] - 28'h0000001;
				if (st_r.cnt[g] == 28'h0000001)
					st_nxt.act[g] = 1'b0;
			end else if (fire[g]) begin
				st_nxt.act[g] = 1'b1;
				st_nxt.cnt[g] = dur;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign pulse = st_r.act;
endmodule
`default_nettype wire

// file: verification/meter_cfg_asserts.sv
// port assertions for the meter configuration register bank
`timescale 1ns/1ns
`default_nettype none
module meter_cfg_asserts (
	input wire logic        ref_clk,          // clock
	input wire logic        rstn,             // reset, active low
	input wire logic        reg_wr,           // write strobe
	input wire logic        reg_rd,           // read strobe
	input wire logic [5:0]  reg_page,         // page
	input wire logic [5:0]  reg_addr,         // address
	input wire logic [23:0] reg_wdata,        // write data
	input wire logic [23:0] reg_rdata,        // read data
	input wire logic        reg_hit,          // read hit
	input wire logic [5:0]  power_sign,       // sign levels
	input wire logic        irq_level,        // interrupt
	input wire logic [3:0]  dout_o,           // pin values
	input wire logic [3:0]  dout_oe,          // pin enables
	input wire logic        freq_meas_done,   // freq ready
	input wire logic        epsilon_update,   // gain load
	input wire logic        owr_tick,         // word rate tick
	input wire logic [23:0] i1_out,           // aligned current 1
	input wire logic [15:0] bit_rate_divisor  // serial divisor
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// --------------------
	// pin routing: source write, then a quiet cycle
	// --------------------
	sequence s_pin(logic [3:0] c);
		reg_wr && reg_page == 6'h00 && reg_addr == 6'h01 && reg_wdata[3:0] == c && !reg_wdata[16] ##1 !reg_wr;
	endsequence
	a_hiz_release: assert property (s_pin(4'he) |=> !dout_oe[0])
		else $error("hi-z pin driven");
	a_irq_route: assert property (s_pin(4'hf) |=> dout_oe[0] && dout_o[0] == $past(irq_level))
		else $error("irq not on pin");
	a_sign_route: assert property (s_pin(4'h4) |=> dout_oe[0] && dout_o[0] == $past(power_sign[0]))
		else $error("sign not on pin");
	// register port, config levels, gain load and coarse delay hold
	a_unmapped_read: assert property (reg_rd && reg_page == 6'h3f |=> !reg_hit && reg_rdata == 24'h0)
		else $error("unmapped hit");
	a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("rdata moved");
	a_divisor_write: assert property (reg_wr && reg_page == 6'h00 && reg_addr == 6'h07
		|=> bit_rate_divisor == $past(reg_wdata[15:0]))
		else $error("divisor not written");
	a_gain_cause: assert property (epsilon_update |-> $past(freq_meas_done))
		else $error("stray gain load");
	a_coarse_hold: assert property (!owr_tick |=> $stable(i1_out))
		else $error("i1_out moved");
endmodule
bind meter_config_registers meter_cfg_asserts i_meter_cfg_asserts (.ref_clk, .rstn, .reg_wr, .reg_rd, .reg_page,
	.reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .power_sign, .irq_level, .dout_o, .dout_oe, .freq_meas_done,
	.epsilon_update, .owr_tick, .i1_out, .bit_rate_divisor);
`default_nettype wire

// file: verification/meter_config_registers_bench.sv
// self-checking bench for the meter configuration register bank
`timescale 1ns/1ns
`default_nettype none
module meter_config_registers_bench;
	logic        ref_clk, rstn, reg_wr, reg_rd, reg_hit, p_avg_valid, freq_meas_done, epsilon_update, owr_tick;
	logic        volt_zero_cross, curr_zero_cross, irq_level, averaging_basis, serial_checksum_disable;
	logic [3:0]  gen_fire, dout_o, dout_oe;
	logic [5:0]  reg_page, reg_addr, power_sign;
	logic [15:0] bit_rate_divisor;
	logic [23:0] reg_wdata, reg_rdata, p1_avg_in, p2_avg_in, p1_avg_store, p2_avg_store, i1_in, v1_in, i1_out, v1_out;
	int          mismatches, compares;
	// short pulse counts keep each pulse brief
	meter_config_registers #(.PULSE_BASE_CYCLES(10), .PULSE_STEP_HALVES(4)) i_meter_config_registers (
		.ref_clk, .rstn, .reg_wr, .reg_rd, .reg_page, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .gen_fire,
		.power_sign, .volt_zero_cross, .curr_zero_cross, .irq_level, .dout_o, .dout_oe, .p_avg_valid, .p1_avg_in,
		.p2_avg_in, .p1_avg_store, .p2_avg_store, .freq_meas_done, .epsilon_update, .owr_tick, .i1_in, .v1_in,
		.i2_in(24'h0), .v2_in(24'h0), .i1_out, .v1_out, .i2_out(), .v2_out(), .fine_phase_pair1(),
		.fine_phase_pair2(), .apparent_power_method(), .zero_cross_lowpass(), .averaging_basis,
		.critical_checksum_disable(), .current1_filter_select(), .current2_filter_select(),
		.voltage1_filter_select(), .voltage2_filter_select(), .decimation_lowpass_bypass(),
		.receive_pullup_disable(), .serial_checksum_disable, .bit_rate_divisor, .pulse_freq_range());
	// --------------------
	// bus and check helpers
	// --------------------
	task chk(input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t saw %h want %h", $time, seen, exp);
		end
	endtask
	task nx;
		@(posedge ref_clk);
		#1;
	endtask
	task wr(input logic [5:0] p, input logic [5:0] a, input logic [23:0] d);
		@(posedge ref_clk);
		{reg_wr, reg_page, reg_addr, reg_wdata} <= {1'b1, p, a, d};
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [5:0] p, input logic [5:0] a, output logic [23:0] d);
		@(posedge ref_clk);
		{reg_rd, reg_page, reg_addr} <= {1'b1, p, a};
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task step(input logic [23:0] i, input logic [23:0] v);
		@(posedge ref_clk);
		{owr_tick, i1_in, v1_in} <= {1'b1, i, v};
		@(posedge ref_clk);
		owr_tick <= 1'b0;
		#1;
	endtask
	// reset values, writable bits, defaults back
	task t_regs;
		logic [23:0] d;
		logic [11:0] loc [5];
		logic [23:0] rv [5];
		logic [23:0] rb [5];
		loc = '{12'h001, 12'h400, 12'h005, 12'h007, 12'h008};
		rv = '{24'h00eeee, 24'h060200, 24'h0, 24'h02004d, 24'h1};
		rb = '{24'hffffff, 24'h465fff, 24'hf3ffff, 24'h06ffff, 24'h0fffff};
		for (int i = 0; i < 5; i++) begin
			rd(loc[i][11:6], loc[i][5:0], d);
			chk(d, rv[i]);
			wr(loc[i][11:6], loc[i][5:0], 24'hffffff);
			rd(loc[i][11:6], loc[i][5:0], d);
			chk(d, rb[i]);
			if (i == 3) chk({7'h0, serial_checksum_disable, bit_rate_divisor}, 24'h01ffff);
			if (i == 1) chk(24'(averaging_basis), 24'h1);
			wr(loc[i][11:6], loc[i][5:0], rv[i]);
		end
		rd(6'h3f, 6'h3f, d);
		chk({d[22:0], reg_hit}, 24'h0);
		$display("registers done");
	endtask
	// all source codes, then open-drain
	task t_pins;
		logic [3:0] c;
		{power_sign, volt_zero_cross, curr_zero_cross, irq_level} <= {6'h2a, 1'b1, 1'b0, 1'b1};
		for (int k = 0; k < 16; k++) begin
			c = 4'(k);
			wr(6'h00, 6'h01, {8'h00, c, c, c, c});
			nx;
			chk(24'(dout_oe), {20'h0, {4{!(c == 4'ha || c == 4'hd || c == 4'he)}}});
			if (dout_oe[0] === 1'b1) chk(24'(dout_o[0]), 24'(c < 4'h4 ? 1'b0 : c < 4'ha ? power_sign[c - 4'h4] :
				c == 4'hb ? volt_zero_cross : c == 4'hc ? curr_zero_cross : irq_level));
		end
		wr(6'h00, 6'h01, 24'h0fffff);
		nx;
		chk(24'(dout_oe), 24'h0);
		@(posedge ref_clk);
		irq_level <= 1'b0;
		nx;
		chk({dout_oe, dout_o}, 24'hf0);
		wr(6'h00, 6'h01, 24'heeee);
		$display("pins done");
	endtask
	// generator one off then on; count high cycles
	task t_pulse;
		int n;
		wr(6'h00, 6'h08, 24'h2);
		for (int e = 0; e < 2; e++) begin
			wr(6'h00, 6'h01, e == 0 ? 24'h00eee0 : 24'h10eee0);
			@(posedge ref_clk);
			gen_fire <= 4'h1;
			@(posedge ref_clk);
			gen_fire <= 4'h0;
			n = 0;
			repeat (30) begin
				nx;
				n += int'(dout_o[0] === 1'b1);
			end
			chk(24'(n), e == 0 ? 24'd0 : 24'd14);
		end
		wr(6'h00, 6'h01, 24'h00eeee);
		$display("pulse done");
	endtask
	// clamp, gain gate, coarse delay
	task t_path;
		for (int m = 0; m < 3; m++) begin
			wr(6'h10, 6'h00, m == 0 ? 24'h460200 : m == 1 ? 24'h060000 : 24'h060200);
			@(posedge ref_clk);
			{p_avg_valid, p1_avg_in, p2_avg_in, freq_meas_done} <= {1'b1, 24'h800001, 24'h123, 1'b1};
			@(posedge ref_clk);
			{p_avg_valid, freq_meas_done} <= 2'b00;
			#1 chk({p1_avg_store[23], p1_avg_store[0], 22'(p2_avg_store)}, {m != 0, m != 0, 22'h123});
			chk(24'(epsilon_update), 24'(m != 1));
		end
		wr(6'h00, 6'h05, 24'h100000);
		step(24'h1, 24'h5);
		step(24'h2, 24'h6);
		chk(i1_out ^ v1_out, 24'h7);
		wr(6'h00, 6'h05, 24'h300000);
		step(24'h3, 24'h7);
		step(24'h4, 24'h8);
		step(24'h5, 24'h9);
		chk(v1_out ^ i1_out, 24'h2);
		$display("path done");
	endtask
	task test_done;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// watchdog far past the test length
	initial begin
		#200000;
		mismatches++;
		test_done;
	end
	initial begin
		{rstn, reg_wr, reg_rd, reg_page, reg_addr, reg_wdata, gen_fire, power_sign} = '0;
		{volt_zero_cross, curr_zero_cross, irq_level, p_avg_valid, p1_avg_in, p2_avg_in} = '0;
		{freq_meas_done, owr_tick, i1_in, v1_in, mismatches, compares} = '0;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		t_regs;
		t_pins;
		t_pulse;
		t_path;
		test_done;
	end
endmodule
`default_nettype wire
